// [hdl/camera_rx_phy_timing_config.sv]
// Operation
// - 15-bit lane init count over two bytes
// - 16-bit self-test pattern length over two bytes
// - 8-bit data lane settle count, resets zero
// - 8-bit sync timeout count driven to receiver
// - 3-bit clock lane settle, bit 3 reserved
// - bit 2 selects subLVDS (1) or MIPI (0)
// - analog trim fields are plain storage
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module camera_rx_phy_timing_config
   import phy_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [14:0] lane_init_count,
   output logic [15:0] selftest_pattern_length,
   output logic [7:0] data_lane_settle_count,
   output logic [7:0] data_lane_sync_timeout,
   output logic [2:0] clock_lane_settle_count,
   output logic [3:0] equaliser_trim,
   output logic [1:0] detector_trim,
   output logic [1:0] low_power_trim_select,
   output logic debug_data_swap,
   output logic signalling_standard_select,
   output logic pullup_keep_on,
   output logic equaliser_load
);

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic [NUM_REGS-1:0] hit;
   logic any_hit;
   logic setup_phase;
   logic access_done;
   logic [NUM_REGS-1:0] wr_en;
   logic [7:0] reg_q [NUM_REGS];
   logic [7:0] rd_byte;
   logic pready_q;
   logic pslverr_q;
   logic [DATA_W-1:0] prdata_q;

   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         hit[i] = (paddr == {2'b00, REG_IDX[i], 2'b00});
      end
   end

   assign any_hit = |hit;
   assign setup_phase = psel && !penable && !pready_q;
   assign access_done = psel && penable && pready_q;

   // only lane 0 of the strobe carries the byte-wide register
   always_comb begin
      for (int i = 0; i < NUM_REGS; i++) begin
         wr_en[i] = access_done && pwrite && pstrb[0] && hit[i] && !pslverr_q;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (hit[i]) begin
            rd_byte = reg_q[i];
         end
      end
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++) begin : g_reg
         cfg_byte_reg #(
            .RESET_VAL(REG_RESET),
            .WMASK(REG_WMASK[g])
         ) u_reg (
            .clk(clk),
            .rst(rst),
            .wr_en(wr_en[g]),
            .wr_data(pwdata[7:0]),
            .q(reg_q[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // apb answer
   // ----------------------------------------
   // one wait-free access cycle: answer is prepared during setup
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_q <= 1'b0;
      end else begin
         pready_q <= setup_phase;
      end
   end

   // unmapped addresses answer with an error and write nothing
   always_ff @(posedge clk) begin
      if (rst) begin
         pslverr_q <= 1'b0;
      end else if (setup_phase) begin
         pslverr_q <= !any_hit;
      end else if (access_done) begin
         pslverr_q <= 1'b0;
      end
   end

   // reads have no side effect, data is latched only
   always_ff @(posedge clk) begin
      if (rst) begin
         prdata_q <= '0;
      end else if (setup_phase && !pwrite) begin
         prdata_q <= {24'h000000, rd_byte};
      end else if (access_done) begin
         prdata_q <= '0;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // ----------------------------------------
   // static configuration to the receiver
   // ----------------------------------------
   assign lane_init_count = {reg_q[1][6:0], reg_q[0]};
   assign selftest_pattern_length = {reg_q[3], reg_q[2]};
   assign data_lane_settle_count = reg_q[4];
   // the receiver counts this down while hunting for the sync leader
   assign data_lane_sync_timeout = reg_q[5];
   assign clock_lane_settle_count = reg_q[6][POS_CLK_SETTLE +: 3];
   assign equaliser_trim = reg_q[6][POS_EQ_TRIM +: 4];
   assign detector_trim = reg_q[7][POS_DETECTOR +: 2];
   assign low_power_trim_select = reg_q[7][POS_LP_SEL +: 2];
   assign debug_data_swap = reg_q[7][POS_DEBUG_SWAP];
   assign signalling_standard_select = reg_q[7][POS_SIGNALLING];
   assign pullup_keep_on = reg_q[7][POS_PULLUP];
   assign equaliser_load = reg_q[7][POS_EQ_LOAD];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic wr_lo_init;
   logic wr_hi_init;
   logic wr_pattern_lo;
   logic wr_pattern_hi;
   logic wr_settle;
   logic wr_sync;
   logic wr_clk_trim;
   logic wr_sig;
   logic any_wr;
   logic past_valid_q;

   assign wr_lo_init = wr_en[0];
   assign wr_hi_init = wr_en[1];
   assign wr_pattern_lo = wr_en[2];
   assign wr_pattern_hi = wr_en[3];
   assign wr_settle = wr_en[4];
   assign wr_sync = wr_en[5];
   assign wr_clk_trim = wr_en[6];
   assign wr_sig = wr_en[7];
   assign any_wr = |wr_en;

   always_ff @(posedge clk) begin
      if (rst) begin
         past_valid_q <= 1'b0;
      end else begin
         past_valid_q <= 1'b1;
      end
   end

   lane_init_lo_a: assert property (@(posedge clk) disable iff (rst)
      wr_lo_init |=> lane_init_count[7:0] == $past(pwdata[7:0]) &&
         lane_init_count[14:8] == $past(lane_init_count[14:8]))
      else $error("lane init low byte not stored");

   lane_init_hi_a: assert property (@(posedge clk) disable iff (rst)
      wr_hi_init |=> lane_init_count[14:8] == $past(pwdata[6:0]) && reg_q[1][7] == 1'b0)
      else $error("lane init high part wrong or reserved bit set");

   pattern_hi_a: assert property (@(posedge clk) disable iff (rst)
      wr_pattern_hi |=> selftest_pattern_length[15:8] == $past(pwdata[7:0]) &&
         selftest_pattern_length[7:0] == $past(selftest_pattern_length[7:0]))
      else $error("pattern length high byte not stored");

   settle_reset_a: assert property (@(posedge clk)
      !rst && !past_valid_q |-> data_lane_settle_count == 8'h00)
      else $error("data settle count not zero after reset");

   settle_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_settle |=> data_lane_settle_count == $past(pwdata[7:0]))
      else $error("data settle count not stored");

   sync_hold_a: assert property (@(posedge clk) disable iff (rst)
      wr_sync ##1 !wr_sync [*3] |-> data_lane_sync_timeout == $past(pwdata[7:0], 4))
      else $error("sync timeout not held after write");

   clk_settle_a: assert property (@(posedge clk) disable iff (rst)
      wr_clk_trim |=> clock_lane_settle_count == $past(pwdata[2:0]) && reg_q[6][3] == 1'b0)
      else $error("clock settle field wrong or reserved bit set");

   signalling_a: assert property (@(posedge clk) disable iff (rst)
      wr_sig |=> signalling_standard_select == ($past(pwdata[2]) ? SIGNALLING_SUBLVDS : SIGNALLING_MIPI))
      else $error("signalling select does not follow write");

   trim_store_a: assert property (@(posedge clk) disable iff (rst)
      wr_sig |=> {detector_trim, low_power_trim_select, debug_data_swap, pullup_keep_on,
         equaliser_load} == {$past(pwdata[7:3]), $past(pwdata[1:0])})
      else $error("trim fields not stored");

   static_cfg_a: assert property (@(posedge clk) disable iff (rst)
      !any_wr |=> $stable(lane_init_count) && $stable(selftest_pattern_length) &&
         $stable(data_lane_settle_count) && $stable(data_lane_sync_timeout) &&
         $stable(reg_q[6]) && $stable(reg_q[7]))
      else $error("configuration changed without a write");

   read_answer_a: assert property (@(posedge clk) disable iff (rst)
      setup_phase && !pwrite && any_hit |=> pready && prdata == {24'h000000, $past(rd_byte)})
      else $error("read answer wrong");

   unmapped_a: assert property (@(posedge clk) disable iff (rst)
      setup_phase && !any_hit |=> pready && pslverr && !any_wr)
      else $error("unmapped access not refused");

   pattern_lo_a: assert property (@(posedge clk) disable iff (rst)
      wr_pattern_lo |=> selftest_pattern_length[7:0] == $past(pwdata[7:0]) &&
         selftest_pattern_length[15:8] == $past(selftest_pattern_length[15:8]))
      else $error("pattern length low byte not stored");

   lane_init_pair_a: assert property (@(posedge clk) disable iff (rst)
      wr_hi_init |=> lane_init_count[7:0] == $past(lane_init_count[7:0]))
      else $error("lane init low byte disturbed by high write");

   sync_write_a: assert property (@(posedge clk) disable iff (rst)
      wr_sync |=> data_lane_sync_timeout == $past(pwdata[7:0]))
      else $error("sync timeout not stored");

   eq_trim_a: assert property (@(posedge clk) disable iff (rst)
      wr_clk_trim |=> equaliser_trim == $past(pwdata[7:4]))
      else $error("equaliser trim not stored");

   trim_reset_a: assert property (@(posedge clk)
      !rst && !past_valid_q |-> {equaliser_trim, detector_trim, low_power_trim_select, debug_data_swap,
         signalling_standard_select, pullup_keep_on, equaliser_load} == 12'h000)
      else $error("trim fields not zero after reset");

   reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
      reg_q[1][7] == 1'b0 && reg_q[6][3] == 1'b0)
      else $error("reserved bit holds a one");

   strobe_ignore_a: assert property (@(posedge clk) disable iff (rst)
      access_done && pwrite && !pstrb[0] |=> $stable(lane_init_count) &&
         $stable(selftest_pattern_length) && $stable(reg_q[4]) && $stable(reg_q[5]) &&
         $stable(reg_q[6]) && $stable(reg_q[7]))
      else $error("write without byte strobe changed a register");

   read_no_side_a: assert property (@(posedge clk) disable iff (rst)
      access_done && !pwrite |=> $stable(lane_init_count) &&
         $stable(selftest_pattern_length) && $stable(reg_q[4]) && $stable(reg_q[5]) &&
         $stable(reg_q[6]) && $stable(reg_q[7]))
      else $error("read changed a register");

   // ----------------------------------------
   // bus answer timing
   // ----------------------------------------
   ready_pulse_a: assert property (@(posedge clk) disable iff (rst)
      pready |=> !pready)
      else $error("pready held longer than one cycle");

   ready_after_setup_a: assert property (@(posedge clk) disable iff (rst)
      pready |-> $past(psel) && !$past(penable))
      else $error("pready without a setup cycle");

   error_with_ready_a: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready)
      else $error("pslverr outside the access cycle");

   idle_data_a: assert property (@(posedge clk) disable iff (rst)
      !pready |-> prdata == 32'h00000000)
      else $error("read data not zero outside a read answer");

   write_answer_a: assert property (@(posedge clk) disable iff (rst)
      setup_phase && pwrite && any_hit |=> pready && !pslverr && prdata == 32'h00000000)
      else $error("write answer wrong");

   write_cov: cover property (@(posedge clk) disable iff (rst) wr_sig ##[1:20] wr_settle);
   read_cov: cover property (@(posedge clk) disable iff (rst) access_done && !pwrite && !pslverr);
   error_cov: cover property (@(posedge clk) disable iff (rst) access_done && pslverr);
   sublvds_cov: cover property (@(posedge clk) disable iff (rst) $rose(signalling_standard_select));
   strobe_cov: cover property (@(posedge clk) disable iff (rst) access_done && pwrite && !pstrb[0]);

endmodule

// [hdl/cfg_byte_reg.sv]
`timescale 1ns/1ps
module cfg_byte_reg
   import phy_cfg_pkg::*;
#(
   parameter logic [7:0] RESET_VAL = 8'h00,
   parameter logic [7:0] WMASK = 8'hff
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] q
);

   // unwritable bits stay at their reset value
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= RESET_VAL;
      end else if (wr_en) begin
         q <= (wr_data & WMASK) | (RESET_VAL & ~WMASK);
      end
   end

endmodule

// [hdl/phy_cfg_pkg.sv]
package phy_cfg_pkg;

   // ----------------------------------------
   // bus geometry
   // ----------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int NUM_REGS = 8;

   // ----------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------
   localparam logic [7:0] IDX_LANE_INIT_LO = 8'h64;
   localparam logic [7:0] IDX_LANE_INIT_HI = 8'h65;
   localparam logic [7:0] IDX_PATTERN_LO = 8'h66;
   localparam logic [7:0] IDX_PATTERN_HI = 8'h67;
   localparam logic [7:0] IDX_DATA_SETTLE = 8'h68;
   localparam logic [7:0] IDX_DATA_SYNC = 8'h69;
   localparam logic [7:0] IDX_CLK_SETTLE_TRIM = 8'h6a;
   localparam logic [7:0] IDX_SIGNALLING_TRIM = 8'h6b;

   localparam logic [7:0] REG_IDX [NUM_REGS] = '{
      IDX_LANE_INIT_LO, IDX_LANE_INIT_HI, IDX_PATTERN_LO, IDX_PATTERN_HI,
      IDX_DATA_SETTLE, IDX_DATA_SYNC, IDX_CLK_SETTLE_TRIM, IDX_SIGNALLING_TRIM};

   // ----------------------------------------
   // reset values and writable bits (reserved bits hold zero)
   // ----------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_LANE_INIT_HI = 8'h7f;
   localparam logic [7:0] MASK_CLK_SETTLE_TRIM = 8'hf7;

   localparam logic [7:0] REG_WMASK [NUM_REGS] = '{
      MASK_FULL, MASK_LANE_INIT_HI, MASK_FULL, MASK_FULL,
      MASK_FULL, MASK_FULL, MASK_CLK_SETTLE_TRIM, MASK_FULL};

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int POS_CLK_SETTLE = 0;
   localparam int POS_EQ_TRIM = 4;
   localparam int POS_DEBUG_SWAP = 3;
   localparam int POS_SIGNALLING = 2;
   localparam int POS_PULLUP = 1;
   localparam int POS_EQ_LOAD = 0;
   localparam int POS_LP_SEL = 4;
   localparam int POS_DETECTOR = 6;

   // ----------------------------------------
   // signalling standard encoding
   // ----------------------------------------
   localparam logic SIGNALLING_SUBLVDS = 1'b1;
   localparam logic SIGNALLING_MIPI = 1'b0;

endpackage

// [testbench/camera_rx_phy_timing_config_bench.sv]
`timescale 1ns/1ps
module camera_rx_phy_timing_config_bench
   import phy_cfg_pkg::*;
;
   // ----------------------------------------
   // stimulus, observation and bookkeeping
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, debug_data_swap, signalling_standard_select, pullup_keep_on, equaliser_load;
   logic [14:0] lane_init_count;
   logic [15:0] selftest_pattern_length;
   logic [7:0] data_lane_settle_count, data_lane_sync_timeout;
   logic [2:0] clock_lane_settle_count;
   logic [3:0] equaliser_trim;
   logic [1:0] detector_trim, low_power_trim_select;
   int num_errors = 0;
   int checked = 0;
   int seed = 32'h668befa5;
   logic [7:0] m [NUM_REGS];
   logic [7:0] rec [NUM_REGS] = '{8'he2, 8'h0a, 8'h00, 8'h01, 8'h0c, 8'h30, 8'h7a, 8'h42};
   logic [ADDR_W-1:0] bad [5] = '{12'h191, 12'h18c, 12'h1b0, 12'h000, 12'hfff};

   camera_rx_phy_timing_config i_camera_rx_phy_timing_config (.clk, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .lane_init_count, .selftest_pattern_length,
      .data_lane_settle_count, .data_lane_sync_timeout, .clock_lane_settle_count, .equaliser_trim,
      .detector_trim, .low_power_trim_select, .debug_data_swap, .signalling_standard_select,
      .pullup_keep_on, .equaliser_load);

   initial begin
      forever #25 clk = ~clk;
   end

   // ----------------------------------------
   // expectation helpers
   // ----------------------------------------
   function automatic logic [ADDR_W-1:0] addr(input int i);
      return {2'b00, REG_IDX[i], 2'b00};
   endfunction

   function automatic int idx(input logic [ADDR_W-1:0] a);
      for (int i = 0; i < NUM_REGS; i++) begin
         if (a === addr(i)) return i;
      end
      return -1;
   endfunction

   function automatic logic [61:0] exp_out();
      return {m[1][6:0], m[0], m[3], m[2], m[4], m[5], m[6][2:0], m[6][7:4], m[7]};
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: mismatch got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // bus master; request held until pready is seen
   // ----------------------------------------
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [3:0] s, output logic [DATA_W-1:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) check(64'h0, 64'h1);
      r = prdata;
      e = pslverr;
   endtask

   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
      logic [DATA_W-1:0] r;
      logic e;
      int k;
      k = idx(a);
      // strobes stay low on reads
      apb(w, a, {24'($random(seed)), d}, w ? s : 4'h0, r, e);
      check(64'(e), 64'(k < 0));
      if (!w) check(64'(r), (k < 0) ? 64'h0 : 64'(m[k]));
      else if (k >= 0 && s[0]) m[k] = d & REG_WMASK[k];
   endtask

   // bus goes idle for a cycle so the last write has landed before outputs are compared
   task automatic settle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      check(64'({lane_init_count, selftest_pattern_length, data_lane_settle_count, data_lane_sync_timeout,
         clock_lane_settle_count, equaliser_trim, detector_trim, low_power_trim_select, debug_data_swap,
         signalling_standard_select, pullup_keep_on, equaliser_load}), 64'(exp_out()));
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic [ADDR_W-1:0] a;
      for (int i = 0; i < NUM_REGS; i++) m[i] = REG_RESET;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      settle();
      for (int i = 0; i < NUM_REGS; i++) xfer(1'b0, addr(i), 8'h00, 4'h0);
      $display("test reset values done");
      for (int i = 0; i < NUM_REGS; i++) xfer(1'b1, addr(i), rec[i], 4'hf);
      settle();
      check(64'(lane_init_count), 64'h0ae2);
      check(64'(data_lane_settle_count), 64'h0c);
      $display("test recommended values done");
      // all ones exposes any reserved bit that stores
      for (int i = 0; i < NUM_REGS; i++) begin
         xfer(1'b1, addr(i), 8'hff, 4'h1);
         xfer(1'b0, addr(i), 8'h00, 4'h0);
      end
      xfer(1'b1, addr(0), 8'h00, 4'he);
      settle();
      $display("test reserved bits done");
      for (int v = 1; v >= 0; v--) begin
         xfer(1'b1, addr(7), {5'h00, v[0], 2'b00}, 4'h1);
         settle();
         check(64'(signalling_standard_select), v ? 64'(SIGNALLING_SUBLVDS) : 64'(SIGNALLING_MIPI));
      end
      $display("test signalling select done");
      for (int i = 0; i < 5; i++) begin
         xfer(1'b1, bad[i], 8'h5a, 4'hf);
         xfer(1'b0, bad[i], 8'h00, 4'h0);
      end
      settle();
      $display("test unmapped access done");
      repeat (300) begin
         r = $random(seed);
         a = (r[4:3] == 2'b00) ? r[31:20] : addr(int'(r[2:0]));
         xfer(r[5], a, r[15:8], r[19:16]);
         if (r[6]) settle();
      end
      settle();
      $display("test random traffic done");
      // reset in mid-run must clear every field again
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) m[i] = REG_RESET;
      @(posedge clk);
      settle();
      for (int i = 0; i < NUM_REGS; i++) xfer(1'b0, addr(i), 8'h00, 4'h0);
      settle();
      $display("test mid-run reset done");
      close_out();
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      close_out();
   end
endmodule
